// File: sbc_spi_params.svh
`ifndef SBC_SPI_PARAMS_SVH
`define SBC_SPI_PARAMS_SVH

// Register addresses (7-bit)
`define ADDR_MODE_SUPPLY   7'h01
`define ADDR_SOFTRST_CFG   7'h02

// Frame layout
`define FRAME_BITS         16
`define FRAME_RW_BIT       7
`define FRAME_DATA_LSB     8

// Mode and supply control field positions
`define MODE_MSB           7
`define MODE_LSB           6
`define THIRD_REG_BIT      5
`define SECOND_MODE_MSB    4
`define SECOND_MODE_LSB    3
`define OV_RESTART_BIT     2
`define RESET_THR_MSB      1
`define RESET_THR_LSB      0

// Reset values and restart keep mask
`define MODE_SUPPLY_POR    8'h00
`define MODE_SUPPLY_KEEP   8'h23
`define SOFTRST_CFG_POR    8'h00
`define SOFTRST_OUT_BIT    6

// Timing
`define CLK_PERIOD_NS      25
`define SOFTRST_PULSE_NS   2000
`define SOFTRST_PULSE_CYC  ((`SOFTRST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: sbc_spi_pkg.sv
package sbc_spi_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_SLEEP  = 2'h1,
    MODE_STOP   = 2'h2,
    MODE_SOFTRST = 2'h3
  } op_mode_type;

  typedef enum logic [1:0] {
    SEC_OFF         = 2'h0,
    SEC_NORMAL      = 2'h1,
    SEC_NORMAL_STOP = 2'h2,
    SEC_ALWAYS      = 2'h3
  } second_mode_type;

  typedef enum logic [1:0] {
    FRM_IDLE  = 2'h0,
    FRM_SHIFT = 2'h1,
    FRM_DONE  = 2'h3
  } frame_state_type;

endpackage

// File: spi_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser; a change counts once stages two and three agree
module spi_pin_sync (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [2:0] pinIn,
  output var  logic [2:0] pinOut
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] stable;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  always_comb begin
    nxt_state    = state_ff;
    nxt_state.s1 = pinIn;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    for (int i = 0; i < 3; i++) begin
      if (state_ff.s2[i] == state_ff.s3[i]) begin
        nxt_state.stable[i] = state_ff.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= {4{3'h4}};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pinOut = state_ff.stable;

endmodule

`default_nettype wire

// File: sbc_spi_mode_supply_regs.sv
// What this block does
// [RULE1] Frame is 16 bits: address, access bit, data
// [RULE2] Bit 7 clear reads without modifying register
// [RULE3] Bit 7 set writes data byte to register
// [RULE4] Data bits 0..7 sit in frame bits 8..15
// [RULE5] Reserved bits read zero; master writes zero
// [RULE6] Reset loads power-on values; restart loads restart values
// [RULE7] Only SPI changes control bits, except hardware bits
// [RULE8] Mode and supply register at address 1
// [RULE9] Zero at reset; restart keeps bits 5,1,0
// [RULE10] Mode field: normal, sleep, stop; 11 soft-resets
// [RULE11] Bit 5 enables third regulator
// [RULE12] Bits 4:3 select second regulator state
// [RULE13] Overvoltage always flags; bit 2 gates restart
// [RULE14] Bits 1:0 select one of four reset thresholds
// [RULE15] Stop to sleep via SPI is refused
// [RULE16] Restart rewrites mode field to normal
// [RULE17] Restart or overtemperature forces second regulator off
// [RULE18] Write frame shifts out the previous contents
// [RULE19] Soft reset pulls reset output low unless configured
// [RULE20] Commit only frames of exactly sixteen clocks; the count holds at 1F, so a 48-clock frame is dropped too
`timescale 1ns/100ps
`default_nettype none
`include "sbc_spi_params.svh"

module sbc_spi_mode_supply_regs (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       spiCsB,
  input  wire logic       spiSck,
  input  wire logic       spiMosi,
  output var  logic       spiMiso,
  input  wire logic       restartEvt,
  input  wire logic       overTempEvt,
  input  wire logic       mainOvEvt,
  output var  logic [1:0] opMode,
  output var  logic       thirdRegulatorEnable,
  output var  logic [1:0] secondRegulatorMode,
  output var  logic       mainOvRestartReq,
  output var  logic       mainOvervoltageFlag,
  output var  logic [1:0] mainResetThreshold,
  output var  logic       resetOutputPinB
);

  typedef struct packed {
    sbc_spi_pkg::frame_state_type fsm;
    logic [4:0]                   bitCnt;
    logic [15:0]                  shiftIn;
    logic [7:0]                   shiftOut;
    logic                         sckPrev;
    logic [7:0]                   modeSupply;
    logic [7:0]                   softrstCfg;
    logic                         ovFlag;
    logic                         ovReq;
    logic                         miso;
    logic                         rstOutB;
    logic [6:0]                   rstCnt;
    logic [1:0]                   opMode;
    logic                         third;
    logic [1:0]                   second;
    logic [1:0]                   thr;
  } regs_state_type;

  localparam logic [6:0] PulseCycles = 7'(`SOFTRST_PULSE_CYC);

  regs_state_type state_ff;
  regs_state_type nxt_state;
  logic [2:0]     pinSync;
  logic           csB;
  logic           sck;
  logic           mosi;

  spi_pin_sync i_spi_pin_sync (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .pinIn  ({spiCsB, spiSck, spiMosi}),
    .pinOut (pinSync)
  );

  assign csB  = pinSync[2];
  assign sck  = pinSync[1];
  assign mosi = pinSync[0];

  // Read value of an address; unmapped and reserved bits give zero
  function automatic logic [7:0] readReg(input logic [6:0] addr, input logic [7:0] ms, input logic [7:0] sc);
    logic [7:0] val;
    val = 8'h00;
    if (addr == `ADDR_MODE_SUPPLY) begin
      val = ms; // see [RULE8]
    end else if (addr == `ADDR_SOFTRST_CFG) begin
      val = sc & 8'h40; // see [RULE5]
    end
    return val;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       rise;
    logic       fall;
    logic [6:0] addr;
    logic [7:0] data;
    logic [1:0] newMode;
    rise      = 1'b0;
    fall      = 1'b0;
    addr      = 7'h00;
    data      = 8'h00;
    newMode   = 2'h0;
    nxt_state = state_ff;
    nxt_state.sckPrev = sck;
    rise = sck & ~state_ff.sckPrev;
    fall = ~sck & state_ff.sckPrev;

    // Pulse timer runs first so a soft reset in the same cycle reloads it
    if (!state_ff.rstOutB) begin
      if (state_ff.rstCnt == 7'h00) begin
        nxt_state.rstOutB = 1'b1;
      end else begin
        nxt_state.rstCnt = state_ff.rstCnt - 7'h01;
      end
    end

    unique case (state_ff.fsm)
      sbc_spi_pkg::FRM_IDLE: begin
        if (!csB) begin
          nxt_state.fsm    = sbc_spi_pkg::FRM_SHIFT;
          nxt_state.bitCnt = 5'h00;
        end
      end
      sbc_spi_pkg::FRM_SHIFT: begin
        // Shifting right leaves frame bit i at index i once all sixteen are in
        if (rise) begin
          nxt_state.shiftIn = {mosi, state_ff.shiftIn[15:1]}; // see [RULE1]
          nxt_state.bitCnt  = state_ff.bitCnt + 5'h01;
        end
        // After the first byte, load the old register value for output
        if (fall) begin
          if (state_ff.bitCnt == 5'h08) begin
            nxt_state.shiftOut = readReg(state_ff.shiftIn[14:8], state_ff.modeSupply,
                                         state_ff.softrstCfg); // see [RULE18]
            nxt_state.miso     = nxt_state.shiftOut[0]; // see [RULE4]
          end else if (state_ff.bitCnt > 5'h08) begin
            nxt_state.shiftOut = {1'b0, state_ff.shiftOut[7:1]};
            nxt_state.miso     = state_ff.shiftOut[1];
          end
        end
        if (csB) begin
          nxt_state.fsm = sbc_spi_pkg::FRM_DONE;
        end
      end
      sbc_spi_pkg::FRM_DONE: begin
        nxt_state.fsm  = sbc_spi_pkg::FRM_IDLE;
        nxt_state.miso = 1'b0;
        // Frame bits 0..6 address, bit 7 access, 8..15 data
        addr = state_ff.shiftIn[6:0];
        data = state_ff.shiftIn[15:8]; // see [RULE4]
        if (state_ff.bitCnt == 5'(`FRAME_BITS) && state_ff.shiftIn[`FRAME_RW_BIT]) begin // see [RULE20] see [RULE3]
          if (addr == `ADDR_MODE_SUPPLY) begin
            newMode = data[`MODE_MSB:`MODE_LSB];
            if (state_ff.modeSupply[`MODE_MSB:`MODE_LSB] == sbc_spi_pkg::MODE_STOP &&
                newMode == sbc_spi_pkg::MODE_SLEEP) begin
              newMode = sbc_spi_pkg::MODE_STOP; // see [RULE15]
            end
            if (newMode == sbc_spi_pkg::MODE_SOFTRST) begin
              nxt_state.modeSupply = `MODE_SUPPLY_POR; // see [RULE10] see [RULE9]
              nxt_state.softrstCfg = `SOFTRST_CFG_POR;
              if (!state_ff.softrstCfg[`SOFTRST_OUT_BIT]) begin
                nxt_state.rstOutB = 1'b0; // see [RULE19]
                nxt_state.rstCnt  = PulseCycles - 7'h01;
              end
            end else begin
              nxt_state.modeSupply = {newMode, data[5:0]};
            end
          end else if (addr == `ADDR_SOFTRST_CFG) begin
            nxt_state.softrstCfg = data & 8'h40; // see [RULE5]
          end
        end
        // Read frames leave registers untouched // see [RULE2]
      end
      default: begin
        nxt_state.fsm = sbc_spi_pkg::FRM_IDLE;
      end
    endcase

    if (state_ff.fsm == sbc_spi_pkg::FRM_SHIFT && csB == 1'b0 && state_ff.bitCnt > 5'(`FRAME_BITS)) begin
      nxt_state.bitCnt = 5'h1F; // Frames of 17 or more clocks are never committed; the count holds at 1F see [RULE20]
    end

    // Hardware-modified bits; restart wins over a same-cycle write see [RULE7]
    if (overTempEvt) begin
      nxt_state.modeSupply[`SECOND_MODE_MSB:`SECOND_MODE_LSB] = sbc_spi_pkg::SEC_OFF; // see [RULE17]
    end
    if (restartEvt) begin
      nxt_state.modeSupply = state_ff.modeSupply & `MODE_SUPPLY_KEEP; // see [RULE6] see [RULE9] see [RULE16]
    end

    if (mainOvEvt) begin
      nxt_state.ovFlag = 1'b1; // see [RULE13]
    end
    nxt_state.ovReq = mainOvEvt & state_ff.modeSupply[`OV_RESTART_BIT]; // see [RULE13]

    nxt_state.opMode = nxt_state.modeSupply[`MODE_MSB:`MODE_LSB]; // see [RULE10]
    nxt_state.third  = nxt_state.modeSupply[`THIRD_REG_BIT]; // see [RULE11]
    nxt_state.second = nxt_state.modeSupply[`SECOND_MODE_MSB:`SECOND_MODE_LSB]; // see [RULE12]
    nxt_state.thr    = nxt_state.modeSupply[`RESET_THR_MSB:`RESET_THR_LSB]; // see [RULE14]
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= '{fsm: sbc_spi_pkg::FRM_IDLE, bitCnt: 5'h00, shiftIn: 16'h0000, shiftOut: 8'h00,
                    sckPrev: 1'b0, modeSupply: `MODE_SUPPLY_POR, softrstCfg: `SOFTRST_CFG_POR,
                    ovFlag: 1'b0, ovReq: 1'b0, miso: 1'b0, rstOutB: 1'b1, rstCnt: 7'h00,
                    opMode: 2'h0, third: 1'b0, second: 2'h0, thr: 2'h0}; // see [RULE6]
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign spiMiso              = state_ff.miso;
  assign opMode               = state_ff.opMode;
  assign thirdRegulatorEnable = state_ff.third;
  assign secondRegulatorMode  = state_ff.second;
  assign mainOvRestartReq     = state_ff.ovReq;
  assign mainOvervoltageFlag  = state_ff.ovFlag;
  assign mainResetThreshold   = state_ff.thr;
  assign resetOutputPinB      = state_ff.rstOutB;

endmodule

`default_nettype wire

// File: sbc_spi_mode_supply_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbc_spi_params.svh"

module sbc_spi_mode_supply_regs_asserts (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       spiCsB,
  input wire logic       restartEvt,
  input wire logic       overTempEvt,
  input wire logic       mainOvEvt,
  input wire logic [1:0] opMode,
  input wire logic [1:0] secondRegulatorMode,
  input wire logic       mainOvRestartReq,
  input wire logic       mainOvervoltageFlag,
  input wire logic [1:0] mainResetThreshold,
  input wire logic       resetOutputPinB
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic [7:0] lowCnt_ff;

  // Length of the current reset pulse, so the upper bound can be checked
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_ff <= 8'h00;
    end else begin
      lowCnt_ff <= resetOutputPinB ? 8'h00 : lowCnt_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ov_flag_a: assert property (mainOvEvt |=> mainOvervoltageFlag) else $error("ov flag not set");
  ov_cause_a: assert property (mainOvRestartReq |-> $past(mainOvEvt)) else $error("restart req without ov");
  restart_mode_a: assert property (restartEvt |-> ##[1:3] (opMode == 2'h0 && secondRegulatorMode == 2'h0))
    else $error("restart left mode or second regulator");
  overtemp_off_a: assert property (overTempEvt |-> ##[1:3] secondRegulatorMode == 2'h0)
    else $error("overtemp left second regulator on");
  stop_sleep_a: assert property (opMode == 2'h2 |=> opMode != 2'h1) else $error("stop went to sleep");
  spi_only_a: assert property ($changed(mainResetThreshold) |-> $past(spiCsB, 2))
    else $error("threshold moved in frame");
  pulse_min_a: assert property ($fell(resetOutputPinB) |=> !resetOutputPinB [*8])
    else $error("reset pulse short");
  pulse_max_a: assert property (lowCnt_ff <= 8'(`SOFTRST_PULSE_CYC)) else $error("reset pulse long");
  softrst_clr_a: assert property ($fell(resetOutputPinB) |-> ##[0:3] (opMode == 2'h0 && mainResetThreshold == 2'h0))
    else $error("soft reset left register set");

  restart_c: cover property (restartEvt);
  softrst_c: cover property ($fell(resetOutputPinB));
  ovreq_c: cover property (mainOvRestartReq);
endmodule

bind sbc_spi_mode_supply_regs sbc_spi_mode_supply_regs_asserts i_sbc_spi_mode_supply_regs_asserts (
  .mclk                (mclk),
  .rst_b               (rst_b),
  .spiCsB              (spiCsB),
  .restartEvt          (restartEvt),
  .overTempEvt         (overTempEvt),
  .mainOvEvt           (mainOvEvt),
  .opMode              (opMode),
  .secondRegulatorMode (secondRegulatorMode),
  .mainOvRestartReq    (mainOvRestartReq),
  .mainOvervoltageFlag (mainOvervoltageFlag),
  .mainResetThreshold  (mainResetThreshold),
  .resetOutputPinB     (resetOutputPinB)
);
`default_nettype wire

// File: spi_master_model.sv
`timescale 1ns/100ps
`default_nettype none

module spi_master_model (
  input  wire logic mclk,
  output var  logic csB,
  output var  logic sck,
  output var  logic mosi,
  input  wire logic miso
);
  initial begin
    csB = 1'b1;
    sck = 1'b0;
    mosi = 1'b1;
  end

  // Six mclk per phase gives margin over the three-stage synchroniser
  task automatic xfer(input logic [15:0] frm, input int nBits, output logic [7:0] old);
    @(negedge mclk) csB = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      mosi = frm[i % 16];
      repeat (6) @(negedge mclk);
      if (i > 7 && i < 16) old[i - 8] = miso;
      sck = 1'b1;
      repeat (6) @(negedge mclk);
      sck = 1'b0;
    end
    repeat (6) @(negedge mclk);
    csB = 1'b1;
    mosi = ~mosi; // Released line shows no stale level
    repeat (12) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// File: tb_sbc_spi_mode_supply_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbc_spi_params.svh"
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin mismatches++; $display("FAIL %0t %h %h", $time, a, b); end end

module tb_sbc_spi_mode_supply_regs;
  logic       mclk, rst_b, spiCsB, spiSck, spiMosi, spiMiso, restartEvt, overTempEvt, mainOvEvt;
  logic [1:0] opMode, secondRegulatorMode, mainResetThreshold;
  logic       thirdRegulatorEnable, mainOvRestartReq, mainOvervoltageFlag, resetOutputPinB;
  logic [7:0] expReg, rd;
  logic [1:0] modeSeq [8] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h3, 2'h0};
  int         mismatches, totalChecks, seen;
  integer     seed = 32'h80e8;

  sbc_spi_mode_supply_regs i_sbc_spi_mode_supply_regs (
    .mclk                 (mclk),
    .rst_b                (rst_b),
    .spiCsB               (spiCsB),
    .spiSck               (spiSck),
    .spiMosi              (spiMosi),
    .spiMiso              (spiMiso),
    .restartEvt           (restartEvt),
    .overTempEvt          (overTempEvt),
    .mainOvEvt            (mainOvEvt),
    .opMode               (opMode),
    .thirdRegulatorEnable (thirdRegulatorEnable),
    .secondRegulatorMode  (secondRegulatorMode),
    .mainOvRestartReq     (mainOvRestartReq),
    .mainOvervoltageFlag  (mainOvervoltageFlag),
    .mainResetThreshold   (mainResetThreshold),
    .resetOutputPinB      (resetOutputPinB)
  );
  spi_master_model i_spi_master_model (.mclk(mclk), .csB(spiCsB), .sck(spiSck), .mosi(spiMosi), .miso(spiMiso));

  function automatic logic [7:0] afterWrite(input logic [7:0] old, input logic [7:0] d);
    if (d[7:6] == 2'h3) return 8'h00;
    if (old[7:6] == 2'h2 && d[7:6] == 2'h1) return {2'h2, d[5:0]};
    return d;
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_spi_master_model.xfer({d, 1'b1, a}, 16, rd);
    if (a == `ADDR_MODE_SUPPLY) begin
      `CHK(rd, expReg)
      expReg = afterWrite(expReg, d);
    end
  endtask

  task automatic chk;
    i_spi_master_model.xfer({8'hA5, 1'b0, `ADDR_MODE_SUPPLY}, 16, rd);
    `CHK(rd, expReg)
    `CHK({opMode, thirdRegulatorEnable, secondRegulatorMode, mainResetThreshold}, {expReg[7:3], expReg[1:0]})
  endtask

  task automatic ovPulse(output int hit);
    hit = 0;
    @(negedge mclk) mainOvEvt = 1'b1;
    @(negedge mclk) mainOvEvt = 1'b0;
    repeat (3) begin
      if (mainOvRestartReq === 1'b1) hit = 1;
      @(negedge mclk);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    restartEvt = 1'b0;
    overTempEvt = 1'b0;
    mainOvEvt = 1'b0;
    expReg = `MODE_SUPPLY_POR;
    repeat (12) @(negedge mclk);
    `CHK({resetOutputPinB, mainOvervoltageFlag, mainOvRestartReq}, 3'h4)
    rst_b = 1'b1;
    repeat (6) @(negedge mclk);
    chk();
    // Walk every mode code, random supply settings beside it
    for (int i = 0; i < 8; i++) begin
      wr(`ADDR_MODE_SUPPLY, {modeSeq[i], 6'($random(seed))});
      chk();
    end
    $display("modes done");
    // A 15 or 17 clock frame carrying a soft reset must be dropped
    for (int n = 15; n <= 17; n += 2) begin
      i_spi_master_model.xfer({8'hFF, 1'b1, `ADDR_MODE_SUPPLY}, n, rd);
      chk();
    end
    wr(7'h05, 8'h3C);
    i_spi_master_model.xfer({8'h00, 1'b0, 7'h05}, 16, rd);
    `CHK(rd, 8'h00)
    chk();
    wr(`ADDR_MODE_SUPPLY, 8'h7F);
    @(negedge mclk) restartEvt = 1'b1;
    @(negedge mclk) restartEvt = 1'b0;
    expReg = expReg & `MODE_SUPPLY_KEEP;
    chk();
    wr(`ADDR_MODE_SUPPLY, 8'h9B);
    @(negedge mclk) overTempEvt = 1'b1;
    @(negedge mclk) overTempEvt = 1'b0;
    expReg[4:3] = 2'h0;
    chk();
    $display("restart done");
    wr(`ADDR_MODE_SUPPLY, 8'h04);
    ovPulse(seen);
    `CHK(seen, 1)
    wr(`ADDR_MODE_SUPPLY, 8'h00);
    ovPulse(seen);
    `CHK({seen[0], mainOvervoltageFlag}, 2'h1)
    $display("overvoltage done");
    wr(`ADDR_SOFTRST_CFG, 8'h00);
    wr(`ADDR_MODE_SUPPLY, 8'hC3);
    `CHK({resetOutputPinB, opMode, mainResetThreshold}, 5'h00)
    for (int w = 0; w < 100 && resetOutputPinB !== 1'b1; w++) @(negedge mclk);
    if (resetOutputPinB !== 1'b1) begin
      mismatches++;
    end else begin
      wr(`ADDR_SOFTRST_CFG, 8'h40);
      i_spi_master_model.xfer({8'h00, 1'b0, `ADDR_SOFTRST_CFG}, 16, rd);
      `CHK(rd, 8'h40)
      wr(`ADDR_MODE_SUPPLY, 8'hC2);
      `CHK(resetOutputPinB, 1'b1)
      // Soft reset also brings the configuration register back to zero
      i_spi_master_model.xfer({8'h00, 1'b0, `ADDR_SOFTRST_CFG}, 16, rd);
      `CHK(rd, `SOFTRST_CFG_POR)
      chk();
      $display("soft reset done");
      // Device reset in mid-run brings back the power-on value
      wr(`ADDR_MODE_SUPPLY, 8'h5B);
      @(negedge mclk) rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      `CHK({resetOutputPinB, opMode, mainResetThreshold}, 5'h10)
      rst_b = 1'b1;
      expReg = `MODE_SUPPLY_POR;
      repeat (6) @(negedge mclk);
      chk();
      $display("device reset done");
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
